// ===== rtl/ssc_serial_status.sv
// Serial channel status flags, clock select and register slave
`timescale 1ns/100ps
`default_nettype none
`include "ssc_cfg.svh"

module ssc_serial_status
   import ssc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [`SSC_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Power state
   input wire logic standby,
   // Transmit engine
   input wire logic tx_load,
   input wire logic tx_last_bit,
   output logic [7:0] tx_holding_reg,
   output logic tx_multiproc_bit,
   output logic tx_enable,
   output logic tx_hold,
   // Receive engine
   input wire logic rx_end,
   input wire ssc_rx_evt_t rx_evt,
   output logic rx_enable,
   output logic rx_hold,
   output logic sync_mode,
   // Bit-rate generator
   input wire logic half_bit_tick,
   output logic serial_tick,
   // Serial clock pin
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   // Interrupt request
   output logic tx_end_irq
);

   // ==========================================================
   // Declarations
   logic [7:0] serial_mode_reg, serial_control_reg, rx_data_reg, status;
   logic [31:0] prdata_r;
   logic tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, fer_r, per_r, tx_end_flag_r, mpb_r, tx_multiproc_bit_r;
   logic [7:`SSC_ST_CLR_LO] arm_r, clr, set_ev;
   logic setup, wr_acc, rd_acc, wr_mode, wr_ctrl, wr_status, wr_txhold, rd_status, ctrl_zero;
   logic te, is_sync, rx_stall, rx_take, ovr_ev, fer_ev, per_ev, ok_ev, sck_in_s;
   ssc_ck_mode_t ck_mode;
   ssc_pin_t sck_pin;

   // ==========================================================
   // Helpers
   function automatic logic addr_hit(input logic [`SSC_ADDR_W-1:0] a);
      addr_hit = (a == `SSC_OFS_MODE) || (a == `SSC_OFS_CTRL) ||
                 (a == `SSC_OFS_STATUS) || (a == `SSC_OFS_TXHOLD) ||
                 (a == `SSC_OFS_RXDATA);
   endfunction

   function automatic ssc_ck_mode_t resolve_ck(input logic sync, input logic hi, input logic lo);
      resolve_ck = hi ? SSC_CK_EXT :
                   ((sync || lo) ? SSC_CK_INT_OUT : SSC_CK_INT_IN);
   endfunction

   function automatic logic parity_bad(input logic [7:0] d, input logic p, input logic odd);
      parity_bad = ((^d) ^ p) != odd;
   endfunction

   // ==========================================================
   // Bus decode
   // No wait states: every access completes in its first access cycle
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite & addr_hit(paddr);
   assign rd_acc = psel & penable & ~pwrite;
   assign wr_mode = wr_acc & (paddr == `SSC_OFS_MODE);
   assign wr_ctrl = wr_acc & (paddr == `SSC_OFS_CTRL);
   assign wr_status = wr_acc & (paddr == `SSC_OFS_STATUS);
   assign wr_txhold = wr_acc & (paddr == `SSC_OFS_TXHOLD);
   assign rd_status = rd_acc & (paddr == `SSC_OFS_STATUS);
   assign ctrl_zero = wr_ctrl & (pwdata[7:0] == `SSC_CTRL_RESET);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_hit(paddr);
   assign prdata = prdata_r;

   // ==========================================================
   // Control fields
   assign te = serial_control_reg[`SSC_CTRL_TE];
   assign is_sync = serial_mode_reg[`SSC_MODE_SYNC];
   assign tx_enable = te;
   assign rx_enable = serial_control_reg[`SSC_CTRL_RE];
   assign sync_mode = is_sync;
   assign tx_multiproc_bit = tx_multiproc_bit_r;

   // ==========================================================
   // Mode and control registers
   // Select bits are taken as written; ordering against mode is software's job
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_mode_reg <= `SSC_MODE_RESET;
      end else if (wr_mode) begin
         serial_mode_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_control_reg <= `SSC_CTRL_RESET;
      end else if (wr_ctrl) begin
         serial_control_reg <= pwdata[7:0];
      end
   end

   // ==========================================================
   // Transmit holding register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_holding_reg <= 8'h00;
      end else if (wr_txhold) begin
         tx_holding_reg <= pwdata[7:0];
      end
   end

   // ==========================================================
   // Read data, captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         case (paddr)
            `SSC_OFS_MODE: prdata_r <= {24'h00_0000, serial_mode_reg};
            `SSC_OFS_CTRL: prdata_r <= {24'h00_0000, serial_control_reg};
            `SSC_OFS_STATUS: prdata_r <= {24'h00_0000, status};
            `SSC_OFS_TXHOLD: prdata_r <= {24'h00_0000, tx_holding_reg};
            `SSC_OFS_RXDATA: prdata_r <= {24'h00_0000, rx_data_reg};
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Status assembly
   always_comb begin
      status = 8'h00;
      status[`SSC_ST_TX_EMPTY_FLAG] = tx_empty_flag_r;
      status[`SSC_ST_RX_FULL_FLAG] = rx_full_flag_r;
      status[`SSC_ST_OVERRUN_FLAG] = overrun_flag_r;
      status[`SSC_ST_FER] = fer_r;
      status[`SSC_ST_PER] = per_r;
      status[`SSC_ST_TX_END_FLAG] = tx_end_flag_r;
      status[`SSC_ST_MPB] = mpb_r;
      status[`SSC_ST_TX_MULTIPROC_BIT] = tx_multiproc_bit_r;
   end

   // ==========================================================
   // Read-then-clear tracking
   // Arming uses the value the master actually got, not the live flag
   assign set_ev[`SSC_ST_TX_EMPTY_FLAG] = tx_load;
   assign set_ev[`SSC_ST_RX_FULL_FLAG] = ok_ev;
   assign set_ev[`SSC_ST_OVERRUN_FLAG] = ovr_ev;
   assign set_ev[`SSC_ST_FER] = fer_ev;
   assign set_ev[`SSC_ST_PER] = per_ev;

   assign clr = {$bits(clr){wr_status}} & ~pwdata[`SSC_ST_TX_EMPTY_FLAG:`SSC_ST_CLR_LO] &
                arm_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_r <= '0;
      end else begin
         for (int i = `SSC_ST_CLR_LO; i <= `SSC_ST_TX_EMPTY_FLAG; i++) begin
            if (standby || clr[i] || set_ev[i]) begin
               arm_r[i] <= 1'b0;
            end else if (rd_status && prdata_r[i]) begin
               arm_r[i] <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Transmit-empty
   // A load in the same cycle as a clear wins, so no load is missed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_empty_flag_r <= 1'b1;
      end else if (standby || ctrl_zero || !te) begin
         tx_empty_flag_r <= 1'b1;
      end else if (tx_load) begin
         tx_empty_flag_r <= 1'b1;
      end else if (clr[`SSC_ST_TX_EMPTY_FLAG] || wr_txhold) begin
         tx_empty_flag_r <= 1'b0;
      end
   end

   // ==========================================================
   // Transmit-end and its request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_end_flag_r <= 1'b1;
      end else if (standby || ctrl_zero) begin
         tx_end_flag_r <= 1'b1;
      end else if (tx_last_bit && tx_empty_flag_r) begin
         tx_end_flag_r <= 1'b1;
      end else if (clr[`SSC_ST_TX_EMPTY_FLAG]) begin
         tx_end_flag_r <= 1'b0;
      end
   end

   // Level request; disabling the enable drops it at once
   assign tx_end_irq = tx_end_flag_r & serial_control_reg[`SSC_CTRL_TX_END_IRQ_ENABLE];

   // ==========================================================
   // Receive event classification
   assign rx_stall = overrun_flag_r | fer_r | per_r;
   assign rx_hold = rx_stall;
   assign tx_hold = is_sync & rx_stall;
   assign rx_take = rx_end & ~rx_stall;
   assign ovr_ev = rx_take & rx_full_flag_r;
   assign fer_ev = rx_take & ~rx_full_flag_r & ~is_sync & ~rx_evt.stop;
   assign per_ev = rx_take & ~rx_full_flag_r & ~is_sync & serial_mode_reg[`SSC_MODE_PEN] &
                   parity_bad(rx_evt.data, rx_evt.parity,
                              serial_mode_reg[`SSC_MODE_ODD]);
   assign ok_ev = rx_take & ~rx_full_flag_r & ~fer_ev & ~per_ev;

   // ==========================================================
   // Receive data register
   // Error characters still land here; an overrun character never does
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_reg <= 8'h00;
      end else if (rx_take && !rx_full_flag_r) begin
         rx_data_reg <= rx_evt.data;
      end
   end

   // ==========================================================
   // Receive-full
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_full_flag_r <= 1'b0;
      end else if (standby) begin
         rx_full_flag_r <= 1'b0;
      end else if (ok_ev) begin
         rx_full_flag_r <= 1'b1;
      end else if (clr[`SSC_ST_RX_FULL_FLAG]) begin
         rx_full_flag_r <= 1'b0;
      end
   end

   // ==========================================================
   // Overrun; receive disable does not touch it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_flag_r <= 1'b0;
      end else if (standby) begin
         overrun_flag_r <= 1'b0;
      end else if (ovr_ev) begin
         overrun_flag_r <= 1'b1;
      end else if (clr[`SSC_ST_OVERRUN_FLAG]) begin
         overrun_flag_r <= 1'b0;
      end
   end

   // ==========================================================
   // Framing error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fer_r <= 1'b0;
      end else if (standby) begin
         fer_r <= 1'b0;
      end else if (fer_ev) begin
         fer_r <= 1'b1;
      end else if (clr[`SSC_ST_FER]) begin
         fer_r <= 1'b0;
      end
   end

   // ==========================================================
   // Parity error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_r <= 1'b0;
      end else if (standby) begin
         per_r <= 1'b0;
      end else if (per_ev) begin
         per_r <= 1'b1;
      end else if (clr[`SSC_ST_PER]) begin
         per_r <= 1'b0;
      end
   end

   // ==========================================================
   // Multiprocessor bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mpb_r <= 1'b0;
      end else if (standby) begin
         mpb_r <= 1'b0;
      end else if (rx_take && !rx_full_flag_r && !is_sync && serial_mode_reg[`SSC_MODE_MP]) begin
         mpb_r <= rx_evt.rx_multiproc_bit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_multiproc_bit_r <= 1'b0;
      end else if (standby) begin
         tx_multiproc_bit_r <= 1'b0;
      end else if (wr_status) begin
         tx_multiproc_bit_r <= pwdata[`SSC_ST_TX_MULTIPROC_BIT];
      end
   end

   // ==========================================================
   // Serial clock source
   // External clock is expected at the bit rate; each rising pin edge is one tick, undivided
   assign ck_mode = resolve_ck(is_sync, serial_control_reg[`SSC_CTRL_CLK_SRC_SELECT_HI],
                               serial_control_reg[`SSC_CTRL_CLK_SRC_SELECT_LO]);

   ssc_sync2 u_sck_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(sck_i),
      .q(sck_in_s)
   );

   ssc_clk_sel u_clk_sel (
      .pclk(pclk),
      .presetn(presetn),
      .ck_mode(ck_mode),
      .half_bit_tick(half_bit_tick),
      .sck_in_s(sck_in_s),
      .sck_pin(sck_pin),
      .serial_tick(serial_tick)
   );

   assign sck_o = sck_pin.o;
   assign sck_oe = sck_pin.oe;

endmodule
`default_nettype wire

// ===== rtl/ssc_cfg.svh
// Register map, field positions and reset values of the serial status block
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define SSC_ADDR_W 8
`define SSC_OFS_MODE 8'h00
`define SSC_OFS_CTRL 8'h04
`define SSC_OFS_STATUS 8'h08
`define SSC_OFS_TXHOLD 8'h0c
`define SSC_OFS_RXDATA 8'h10

// ==========================================================
// Status fields
`define SSC_ST_RESET 8'h84
`define SSC_ST_TX_EMPTY_FLAG 7
`define SSC_ST_RX_FULL_FLAG 6
`define SSC_ST_OVERRUN_FLAG 5
`define SSC_ST_FER 4
`define SSC_ST_PER 3
`define SSC_ST_TX_END_FLAG 2
`define SSC_ST_MPB 1
`define SSC_ST_TX_MULTIPROC_BIT 0
`define SSC_ST_CLR_LO 3

// ==========================================================
// Control fields
`define SSC_CTRL_RESET 8'h00
`define SSC_CTRL_TE 5
`define SSC_CTRL_RE 4
`define SSC_CTRL_TX_END_IRQ_ENABLE 2
`define SSC_CTRL_CLK_SRC_SELECT_HI 1
`define SSC_CTRL_CLK_SRC_SELECT_LO 0

// ==========================================================
// Mode fields
`define SSC_MODE_RESET 8'h00
`define SSC_MODE_SYNC 7
`define SSC_MODE_PEN 5
`define SSC_MODE_ODD 4
`define SSC_MODE_MP 2

`endif

// ===== rtl/ssc_pkg.sv
// Shared types of the serial status block
package ssc_pkg;

   // ==========================================================
   // Clock source selection as resolved from mode and select bits
   typedef enum logic [1:0] {
      SSC_CK_INT_IN = 2'h0,
      SSC_CK_INT_OUT = 2'h1,
      SSC_CK_EXT = 2'h3
   } ssc_ck_mode_t;

   // ==========================================================
   // One finished character from the receive shifter
   typedef struct packed {
      logic [7:0] data;
      logic stop;
      logic parity;
      logic rx_multiproc_bit;
   } ssc_rx_evt_t;

   // ==========================================================
   // Serial clock pin drive
   typedef struct packed {
      logic o;
      logic oe;
   } ssc_pin_t;

endpackage

// ===== rtl/ssc_sync2.sv
// Two-flop synchroniser for a level from outside the pclk domain
`timescale 1ns/100ps
`default_nettype none

module ssc_sync2 (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Level
   input wire logic d,
   output logic q
);

   logic meta_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule
`default_nettype wire

// ===== rtl/ssc_clk_sel.sv
// Serial clock source: pin drive, internal clock out and external edge finder
`timescale 1ns/100ps
`default_nettype none

module ssc_clk_sel
   import ssc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Selection
   input wire ssc_ck_mode_t ck_mode,
   input wire logic half_bit_tick,
   // Pin
   input wire logic sck_in_s,
   output ssc_pin_t sck_pin,
   // To shift engines
   output logic serial_tick
);

   logic sck_r;
   logic sck_prev_r;
   logic tick_r;

   // ==========================================================
   // Internal clock, one full period per bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_r <= 1'b1;
      end else if (half_bit_tick) begin
         sck_r <= ~sck_r;
      end
   end

   // ==========================================================
   // Edge finder on the synchronised pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_prev_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         sck_prev_r <= sck_in_s;
         if (ck_mode == SSC_CK_EXT) begin
            // External clock: each rising pin edge is one tick
            tick_r <= sck_in_s & ~sck_prev_r;
         end else begin
            tick_r <= half_bit_tick & sck_r;
         end
      end
   end

   assign serial_tick = tick_r;
   assign sck_pin.o = sck_r;
   assign sck_pin.oe = (ck_mode == SSC_CK_INT_OUT);

endmodule
`default_nettype wire

// ===== verif/ssc_remote_station.sv
// Remote station model on the serial clock pin
`timescale 1ns/100ps
`default_nettype none

module ssc_remote_station (
   // Frame control
   input wire logic run,
   // Pin
   input wire logic sck_o,
   input wire logic sck_oe,
   output logic sck_i
);
   // ==========
   // External clock, still and high between frames
   logic ck = 1'b1;
   always #200 ck = run ? ~ck : 1'b1;
   // Device drive wins, so no contention is modelled
   assign sck_i = sck_oe ? sck_o : ck;
endmodule
`default_nettype wire

// ===== verif/ssc_serial_status_chk.sv
// Assertion checker for the serial status block
`timescale 1ns/100ps
`default_nettype none
`include "ssc_cfg.svh"

module ssc_serial_status_chk
   import ssc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic [`SSC_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Engines and pin
   input wire logic standby,
   input wire logic rx_end,
   input wire ssc_rx_evt_t rx_evt,
   input wire logic rx_hold,
   input wire logic tx_hold,
   input wire logic sync_mode,
   input wire logic half_bit_tick,
   input wire logic serial_tick,
   input wire logic sck_i,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic tx_end_irq
);
   // ==========
   // Control shadow from bus writes
   logic [7:0] ctl_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctl_r <= 8'h00;
      else if (psel && penable && pwrite && paddr == `SSC_OFS_CTRL) ctl_r <= pwdata[7:0];
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========
   // Properties
   a_tx_suspend: assert property (tx_hold == (sync_mode && rx_hold))
      else $error("transmit hold mismatch");
   a_pin_drive: assert property (
      sck_oe == (sync_mode ? !ctl_r[1] : ctl_r[1:0] == 2'b01)) else $error("pin drive mismatch");
   a_irq_gate: assert property (!ctl_r[2] |-> !tx_end_irq)
      else $error("request while disabled");
   a_clk_out_rate: assert property (
      sck_oe && $past(sck_oe) && !sync_mode |-> (sck_o != $past(sck_o)) == $past(half_bit_tick))
      else $error("output clock rate");
   a_ext_edge: assert property (
      ctl_r[1] && $past(ctl_r[1]) && $rose(sck_i) |-> ##[2:3] serial_tick)
      else $error("external edge lost");
   a_frame_err: assert property (
      rx_end && !rx_hold && !sync_mode && !rx_evt.stop |=> rx_hold) else $error("no error flag");
   a_err_sticky: assert property (
      rx_hold && !standby && !(psel && pwrite && paddr == `SSC_OFS_STATUS) |=> rx_hold)
      else $error("error flag lost");
   a_standby_val: assert property (
      standby ##1 (standby && psel && !penable && !pwrite && paddr == `SSC_OFS_STATUS)
      |=> prdata[7:0] == 8'h84) else $error("standby status");

   c_overrun: cover property (rx_end && rx_hold);
   c_irq: cover property (tx_end_irq);
   c_ext: cover property (serial_tick && ctl_r[1]);
endmodule

bind ssc_serial_status ssc_serial_status_chk ssc_serial_status_chk_i (
   .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .standby, .rx_end,
   .rx_evt, .rx_hold, .tx_hold, .sync_mode, .half_bit_tick, .serial_tick, .sck_i, .sck_o,
   .sck_oe, .tx_end_irq);
`default_nettype wire

// ===== verif/ssc_serial_status_tb_top.sv
// Testbench for the serial status block
`timescale 1ns/100ps
`default_nettype none
`include "ssc_cfg.svh"

module ssc_serial_status_tb_top
   import ssc_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic standby = 1'b0, tx_load = 1'b0, tx_last_bit = 1'b0, rx_end = 1'b0, run = 1'b0;
   logic half_bit_tick = 1'b0;
   ssc_rx_evt_t rx_evt = '0;
   logic pready, pslverr, tx_hold, rx_hold, sync_mode, serial_tick, sck_i, sck_o, sck_oe;
   logic tx_end_irq, se;
   logic [7:0] tx_holding_reg;
   logic tx_multiproc_bit, tx_enable, rx_enable;
   logic [7:0] q;
   logic [1:0] hc = 2'h0;
   int err_total = 0, tests_run = 0, nt = 0, n0;

   ssc_serial_status ssc_serial_status_i (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .standby, .tx_load, .tx_last_bit, .tx_holding_reg, .tx_multiproc_bit, .tx_enable,
      .tx_hold, .rx_end, .rx_evt, .rx_enable, .rx_hold, .sync_mode, .half_bit_tick,
      .serial_tick, .sck_i, .sck_o, .sck_oe, .tx_end_irq);
   ssc_remote_station ssc_remote_station_i (.run, .sck_o, .sck_oe, .sck_i);

   // ==========
   // Clock, bit-rate ticks and tick counter
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      hc <= hc + 2'h1;
      half_bit_tick <= (hc == 2'h3);
      if (serial_tick === 1'b1) nt++;
   end

   // ==========
   // Tasks
   task automatic stop_test();
      if (err_total == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic ck(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata[7:0];
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xf(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      xf(1'b0, a, 8'h00);
      ck(q, e);
   endtask
   task automatic pl(input logic [1:0] k);
      {tx_last_bit, tx_load} <= k;
      @(posedge pclk);
      {tx_last_bit, tx_load} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic rxe(input logic [7:0] d, input logic s, input logic p);
      rx_evt <= {d, s, p, 1'b0};
      rx_end <= 1'b1;
      @(posedge pclk);
      rx_end <= 1'b0;
      @(posedge pclk);
   endtask

   // ==========
   // Sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      wr(`SSC_OFS_CTRL, 8'h24);
      wr(`SSC_OFS_STATUS, 8'h00);
      rc(`SSC_OFS_STATUS, 8'h84);
      ck({7'h0, tx_end_irq}, 8'h01);
      wr(`SSC_OFS_STATUS, 8'h7b);
      rc(`SSC_OFS_STATUS, 8'h01);
      ck({6'h0, tx_multiproc_bit, tx_end_irq}, 8'h02);
      wr(`SSC_OFS_TXHOLD, 8'h5a);
      rc(`SSC_OFS_TXHOLD, 8'h5a);
      ck(tx_holding_reg, 8'h5a);
      pl(2'b01);
      rc(`SSC_OFS_STATUS, 8'h81);
      wr(`SSC_OFS_TXHOLD, 8'h3c);
      rc(`SSC_OFS_STATUS, 8'h01);
      pl(2'b01);
      pl(2'b10);
      rc(`SSC_OFS_STATUS, 8'h85);
      ck({7'h0, tx_end_irq}, 8'h01);
      wr(`SSC_OFS_CTRL, 8'h20);
      ck({7'h0, tx_end_irq}, 8'h00);
      wr(`SSC_OFS_CTRL, 8'h30);
      rxe(8'ha5, 1'b1, 1'b0);
      rc(`SSC_OFS_STATUS, 8'hc5);
      rxe(8'h3c, 1'b1, 1'b0);
      rc(`SSC_OFS_STATUS, 8'he5);
      ck({6'h0, rx_hold, tx_hold}, 8'h02);
      rxe(8'h11, 1'b1, 1'b0);
      rc(`SSC_OFS_RXDATA, 8'ha5);
      wr(`SSC_OFS_CTRL, 8'h20);
      ck({6'h0, tx_enable, rx_enable}, 8'h02);
      rc(`SSC_OFS_STATUS, 8'he5);
      wr(`SSC_OFS_MODE, 8'h80);
      ck({6'h0, rx_hold, tx_hold}, 8'h03);
      wr(`SSC_OFS_MODE, 8'h00);
      wr(`SSC_OFS_STATUS, 8'h9f);
      rc(`SSC_OFS_STATUS, 8'h85);
      wr(`SSC_OFS_CTRL, 8'h30);
      rxe(8'h77, 1'b0, 1'b0);
      rc(`SSC_OFS_STATUS, 8'h95);
      rc(`SSC_OFS_RXDATA, 8'h77);
      wr(`SSC_OFS_STATUS, 8'hef);
      wr(`SSC_OFS_MODE, 8'h20);
      rxe(8'h01, 1'b1, 1'b0);
      rc(`SSC_OFS_STATUS, 8'h8d);
      wr(`SSC_OFS_STATUS, 8'hf7);
      wr(`SSC_OFS_MODE, 8'h30);
      rxe(8'h03, 1'b1, 1'b1);
      rc(`SSC_OFS_STATUS, 8'hc5);
      rc(`SSC_OFS_RXDATA, 8'h03);
      standby <= 1'b1;
      @(posedge pclk);
      rc(`SSC_OFS_STATUS, 8'h84);
      standby <= 1'b0;
      wr(`SSC_OFS_RXDATA, 8'hff);
      rc(`SSC_OFS_RXDATA, 8'h03);
      rc(8'h20, 8'h00);
      ck({7'h0, se}, 8'h01);
      for (int m = 0; m < 2; m++) begin
         for (int c = 0; c < 4; c++) begin
            wr(`SSC_OFS_CTRL, 8'(c));
            wr(`SSC_OFS_MODE, 8'(m * 128));
            ck({7'h0, sck_oe}, {7'h0, (m != 0) ? (c < 2) : (c == 1)});
            @(negedge pclk);
            n0 = nt;
            @(posedge pclk);
            run <= (c > 1);
            repeat (80) @(posedge pclk);
            run <= 1'b0;
            repeat (7) @(posedge pclk);
            @(negedge pclk);
            ck(8'(nt - n0), (c > 1) ? 8'd10 : 8'd11);
            @(posedge pclk);
         end
      end
      stop_test();
   end

   initial begin
      #200000;
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
